// *** rtl/accr_pkg.sv ***
`default_nettype none
package accr_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CH1_GAIN_HIGH = 8'h11;
    localparam logic [7:0] IDX_CH1_GAIN_LOW = 8'h12;
    localparam logic [7:0] IDX_CH2_CONFIG = 8'h13;
    localparam logic [7:0] IDX_CH2_OFFSET_HIGH = 8'h14;
    localparam logic [7:0] IDX_CH2_OFFSET_LOW = 8'h15;
    localparam logic [7:0] IDX_CH2_GAIN_HIGH = 8'h16;
    localparam logic [7:0] IDX_CH2_GAIN_LOW = 8'h17;
    // Reset values
    localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
    localparam logic [15:0] RST_GAIN_LOW = 16'h0000;
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    // Writable bit masks
    localparam logic [15:0] MASK_LOW_WORD = 16'hff00;
    localparam logic [15:0] MASK_CONFIG = 16'hffc7;
    // Configuration field positions
    localparam int SHIFT_MSB = 15;
    localparam int SHIFT_LSB = 6;
    localparam int HIGHPASS_OFF_BIT = 2;
    // Answer for an unmapped read
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // Input selection codes
    typedef enum logic [1:0] {
        ACCR_IN_PINS = 2'b00,
        ACCR_IN_SHORT = 2'b01,
        ACCR_IN_TEST_POS = 2'b10,
        ACCR_IN_TEST_NEG = 2'b11
    } accr_input_sel_t;
endpackage : accr_pkg
`default_nettype wire

// *** rtl/accr_regs.sv ***
// Behaviour
// RQ1: Gain is upper word bits 23..8 plus lower word high byte, unsigned.
// RQ2: Upper gain word resets to 8000h, lower gain word to 0000h.
// RQ3: Offset is upper word bits 23..8 plus lower high byte, two's complement.
// RQ4: Low byte of every lower offset or gain word reads zero.
// RQ5: Config bits 15..6 hold signed sample shift, reset zero.
// RQ6: Config bits 5..3 are reserved and read zero.
// RQ7: Config bit 2 set disables the highpass for this channel only.
// RQ8: Config bits 1..0 select pins, shorted, positive or negative test.
// RQ9: Channel 2 config word sits at 13h, resets to 0000h.
// RQ10: Offset words reset to 0000h; channel 2 at 14h and 15h.
// RQ11: Five words per channel in order config, offsets, gains; ends 17h. The code maps only the two gain words (11h, 12h) for channel 1.
// RQ12: Writes to reserved bits are ignored; they keep reading zero.
`default_nettype none
module accr_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [accr_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [accr_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [accr_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // Channel 1 gain value
    output logic [23:0] ch1_gain_value,
    // Channel 2 controls and corrections
    output logic [9:0] ch2_sample_shift,
    output logic ch2_highpass_off,
    output logic [1:0] ch2_input_select,
    output logic [23:0] ch2_offset_value,
    output logic [23:0] ch2_gain_value
);
    import accr_pkg::*;

    logic rst_meta_reg;
    logic rst_sync_n;
    logic ack_reg;
    logic [15:0] ch1_gain_value_high;
    logic [15:0] ch1_gain_value_low;
    logic [15:0] ch2_config;
    logic [15:0] ch2_offset_value_high;
    logic [15:0] ch2_offset_value_low;
    logic [15:0] ch2_gain_value_high;
    logic [15:0] ch2_gain_value_low;
    logic [5:0] index;
    logic aligned;
    logic [15:0] wr_be_mask;
    logic [15:0] read_word;
    logic mapped;
    logic take;

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // Address decode: word index from byte address
    assign index = address[7:2];
    assign aligned = (address[1:0] == 2'b00);
    assign wr_be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign take = (read || write) && !ack_reg;

    // RQ11: consecutive word layout
    always_comb begin
        mapped = aligned;
        read_word = 16'h0000;
        case ({2'b00, index})
            IDX_CH1_GAIN_HIGH: read_word = ch1_gain_value_high;
            // RQ4: low byte reads zero
            IDX_CH1_GAIN_LOW: read_word = ch1_gain_value_low & MASK_LOW_WORD;
            // RQ6: reserved config bits read zero
            IDX_CH2_CONFIG: read_word = ch2_config & MASK_CONFIG;
            IDX_CH2_OFFSET_HIGH: read_word = ch2_offset_value_high;
            IDX_CH2_OFFSET_LOW: read_word = ch2_offset_value_low & MASK_LOW_WORD;
            IDX_CH2_GAIN_HIGH: read_word = ch2_gain_value_high;
            IDX_CH2_GAIN_LOW: read_word = ch2_gain_value_low & MASK_LOW_WORD;
            default: mapped = 1'b0;
        endcase
    end

    // One wait cycle, then acknowledge
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !take;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readdata <= UNMAPPED_DATA;
            response <= 2'b00;
        end else if (take) begin
            readdata <= (read && mapped) ? {16'h0000, read_word} : UNMAPPED_DATA;
            response <= mapped ? 2'b00 : 2'b11;
        end
    end

    // RQ2: gain reset values; RQ12: reserved write bits masked off
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch1_gain_value_high <= RST_GAIN_HIGH;
            ch1_gain_value_low <= RST_GAIN_LOW;
            ch2_gain_value_high <= RST_GAIN_HIGH;
            ch2_gain_value_low <= RST_GAIN_LOW;
        end else if (write && take && aligned) begin
            if ({2'b00, index} == IDX_CH1_GAIN_HIGH)
                ch1_gain_value_high <= (ch1_gain_value_high & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask);
            if ({2'b00, index} == IDX_CH1_GAIN_LOW)
                ch1_gain_value_low <= (ch1_gain_value_low & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask & MASK_LOW_WORD);
            if ({2'b00, index} == IDX_CH2_GAIN_HIGH)
                ch2_gain_value_high <= (ch2_gain_value_high & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask);
            if ({2'b00, index} == IDX_CH2_GAIN_LOW)
                ch2_gain_value_low <= (ch2_gain_value_low & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask & MASK_LOW_WORD);
        end
    end

    // RQ10: offset words reset to zero
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch2_offset_value_high <= RST_OFFSET;
            ch2_offset_value_low <= RST_OFFSET;
        end else if (write && take && aligned) begin
            if ({2'b00, index} == IDX_CH2_OFFSET_HIGH)
                ch2_offset_value_high <= (ch2_offset_value_high & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask);
            if ({2'b00, index} == IDX_CH2_OFFSET_LOW)
                ch2_offset_value_low <= (ch2_offset_value_low & ~wr_be_mask)
                    | (writedata[15:0] & wr_be_mask & MASK_LOW_WORD);
        end
    end

    // RQ9: config word reset and write
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch2_config <= RST_CONFIG;
        end else if (write && take && aligned && {2'b00, index} == IDX_CH2_CONFIG) begin
            ch2_config <= (ch2_config & ~wr_be_mask)
                | (writedata[15:0] & wr_be_mask & MASK_CONFIG);
        end
    end

    // RQ1: unsigned gain assembly
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch1_gain_value <= {RST_GAIN_HIGH, RST_GAIN_LOW[15:8]};
            ch2_gain_value <= {RST_GAIN_HIGH, RST_GAIN_LOW[15:8]};
        end else begin
            ch1_gain_value <= {ch1_gain_value_high, ch1_gain_value_low[15:8]};
            ch2_gain_value <= {ch2_gain_value_high, ch2_gain_value_low[15:8]};
        end
    end

    // RQ3: signed offset assembly
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch2_offset_value <= {RST_OFFSET, RST_OFFSET[15:8]};
        end else begin
            ch2_offset_value <= {ch2_offset_value_high, ch2_offset_value_low[15:8]};
        end
    end

    // RQ5: sample shift field; RQ7: highpass off; RQ8: input select
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ch2_sample_shift <= RST_CONFIG[SHIFT_MSB:SHIFT_LSB];
            ch2_highpass_off <= RST_CONFIG[HIGHPASS_OFF_BIT];
            ch2_input_select <= ACCR_IN_PINS;
        end else begin
            ch2_sample_shift <= ch2_config[SHIFT_MSB:SHIFT_LSB];
            ch2_highpass_off <= ch2_config[HIGHPASS_OFF_BIT];
            ch2_input_select <= ch2_config[1:0];
        end
    end

    // RQ4: reserved low bytes stay zero
    reserved_low_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ4
        (ch1_gain_value_low[7:0] == 8'h00) && (ch2_gain_value_low[7:0] == 8'h00)
        && (ch2_offset_value_low[7:0] == 8'h00))
        else $error("reserved low byte nonzero");

    // RQ6: reserved config bits stay zero
    config_reserved_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ6
        ch2_config[5:3] == 3'b000)
        else $error("reserved config bits nonzero");

    // RQ12: masked write leaves reserved bits
    reserved_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ12
        (write && take && {2'b00, index} == IDX_CH2_CONFIG && aligned)
        |=> (ch2_config[5:3] == 3'b000))
        else $error("config reserved bits written");

    // RQ1: gain output follows words
    gain_assembly_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ1
        ##1 ch2_gain_value == {$past(ch2_gain_value_high), $past(ch2_gain_value_low[15:8])})
        else $error("gain value mismatch");

    // RQ3: offset output follows words
    offset_assembly_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ3
        ##1 ch2_offset_value
            == {$past(ch2_offset_value_high), $past(ch2_offset_value_low[15:8])})
        else $error("offset value mismatch");

    // RQ5: sample shift follows config
    shift_field_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ5
        ##1 ch2_sample_shift == $past(ch2_config[15:6]))
        else $error("sample shift mismatch");

    // RQ7: highpass and select follow config
    highpass_select_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ7
        ##1 (ch2_highpass_off == $past(ch2_config[2]))
            && (ch2_input_select == $past(ch2_config[1:0])))
        else $error("highpass or select mismatch");

    // RQ11: config read returns stored word
    config_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ11
        (read && take && aligned && {2'b00, index} == IDX_CH2_CONFIG)
        |=> (!waitrequest && readdata == {16'h0000, $past(ch2_config)}))
        else $error("config read mismatch");

    // RQ2: gain reset value right after reset
    gain_reset_a: assert property (@(posedge clock) // RQ2
        $rose(rst_sync_n) |-> (ch2_gain_value_high == RST_GAIN_HIGH)
            && (ch1_gain_value_high == RST_GAIN_HIGH))
        else $error("gain reset value wrong");

    // RQ9: config reset value
    config_reset_a: assert property (@(posedge clock) // RQ9
        $rose(rst_sync_n) |-> ch2_config == RST_CONFIG)
        else $error("config reset value wrong");

    // RQ10: offset reset value
    offset_reset_a: assert property (@(posedge clock) // RQ10
        $rose(rst_sync_n) |-> (ch2_offset_value_high == RST_OFFSET)
            && (ch2_offset_value_low == RST_OFFSET))
        else $error("offset reset value wrong");

    // RQ11: one answer per taken request
    bus_answer_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ11
        take |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

    // RQ1: channel 1 gain follows words
    ch1_gain_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ1
        ##1 ch1_gain_value == {$past(ch1_gain_value_high), $past(ch1_gain_value_low[15:8])})
        else $error("channel 1 gain mismatch");

    // RQ2: lower gain words reset to zero
    gain_low_reset_a: assert property (@(posedge clock) // RQ2
        $rose(rst_sync_n) |-> (ch1_gain_value_low == RST_GAIN_LOW)
            && (ch2_gain_value_low == RST_GAIN_LOW))
        else $error("lower gain reset value wrong");

    // RQ4: lower word reads give zero low byte
    low_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ4
        (read && take && ({2'b00, index} == IDX_CH1_GAIN_LOW
            || {2'b00, index} == IDX_CH2_OFFSET_LOW || {2'b00, index} == IDX_CH2_GAIN_LOW))
        |=> (readdata[7:0] == 8'h00))
        else $error("lower word low byte read nonzero");

    // RQ11: unmapped read answers error with zero
    unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ11
        (read && take && !mapped) |=> (response == 2'b11) && (readdata == UNMAPPED_DATA))
        else $error("unmapped read answer wrong");

    // RQ12: stray writes leave registers alone
    stray_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ12
        (write && take && !mapped)
        |=> $stable(ch2_config) && $stable(ch2_offset_value_high)
            && $stable(ch1_gain_value_high) && $stable(ch2_gain_value_high))
        else $error("unmapped write changed a register");

    // RQ8: input select defaults to own pins
    select_reset_a: assert property (@(posedge clock) // RQ8
        $rose(rst_sync_n) |-> ch2_input_select == ACCR_IN_PINS)
        else $error("input select reset value wrong");

    // RQ5: sample shift resets to zero
    shift_reset_a: assert property (@(posedge clock) // RQ5
        $rose(rst_sync_n) |-> (ch2_sample_shift == 10'h000) && !ch2_highpass_off)
        else $error("shift or highpass reset wrong");

    // RQ1: full gain write lands
    gain_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ1
        (write && take && aligned && {2'b00, index} == IDX_CH2_GAIN_HIGH
            && byteenable[1:0] == 2'b11)
        |=> (ch2_gain_value_high == $past(writedata[15:0])))
        else $error("gain word write lost");

    // RQ3: full offset write lands
    offset_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ3
        (write && take && aligned && {2'b00, index} == IDX_CH2_OFFSET_HIGH
            && byteenable[1:0] == 2'b11)
        |=> (ch2_offset_value_high == $past(writedata[15:0])))
        else $error("offset word write lost");

    // RQ12: config write keeps lanes and reserved bits
    config_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // RQ12
        (write && take && aligned && {2'b00, index} == IDX_CH2_CONFIG)
        |=> (ch2_config == (($past(ch2_config) & ~$past(wr_be_mask))
            | ($past(writedata[15:0]) & $past(wr_be_mask) & MASK_CONFIG))))
        else $error("config write result wrong");
endmodule // accr_regs
`default_nettype wire

// *** sim/accr_regs_test.sv ***
`default_nettype none
module accr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import accr_pkg::*;
    logic clock, rst_n, read, write, waitrequest, ch2_highpass_off;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [1:0] response, ch2_input_select, rs;
    logic [9:0] ch2_sample_shift;
    logic [23:0] ch1_gain_value, ch2_offset_value, ch2_gain_value;
    logic [15:0] shadow [7];
    logic [31:0] rng = 32'h0000_0013;
    logic [31:0] rd;
    logic [7:0] bad [4] = '{8'h40, 8'h45, 8'h60, 8'h5d};
    int n_errors = 0;
    int num_checks = 0;

    accr_regs u_accr_regs (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .ch1_gain_value(ch1_gain_value),
        .ch2_sample_shift(ch2_sample_shift), .ch2_highpass_off(ch2_highpass_off),
        .ch2_input_select(ch2_input_select), .ch2_offset_value(ch2_offset_value),
        .ch2_gain_value(ch2_gain_value));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [7:0] addr_of(input int i);
        return 8'h44 + 8'(i * 4);
    endfunction
    function automatic logic [15:0] wmask(input int i);
        if (i == 1 || i == 4 || i == 6) return 16'hff00;
        if (i == 2) return 16'hffc7;
        return 16'hffff;
    endfunction
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("[ERR] %0t value %h expected %h", $time, got, exp);
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("[ERR] %0t response %b expected %b", $time, got, exp);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Held until waitrequest is sampled low; only the watchdog ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] be);
        rng = xs(rng);
        @(posedge clock);
        address <= a;
        writedata <= {rng[31:16], d};
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        rs = response;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic put(input int i, input logic [15:0] d, input logic [3:0] be);
        logic [15:0] bm;
        bm = {{8{be[1]}}, {8{be[0]}}} & wmask(i);
        xfer(1'b1, addr_of(i), d, be);
        shadow[i] = (shadow[i] & ~bm) | (d & bm);
    endtask
    task automatic check_reg(input int i);
        xfer(1'b0, addr_of(i), 16'h0000, 4'hf);
        chk_val(rd, {16'h0000, shadow[i]});
        chk_resp(rs, 2'b00);
    endtask
    task automatic check_all();
        for (int i = 0; i < 7; i++) check_reg(i);
    endtask
    task automatic check_outs();
        @(posedge clock);
        #1;
        chk_val({8'h00, ch1_gain_value}, {8'h00, shadow[0], shadow[1][15:8]});
        chk_val({22'h0, ch2_sample_shift}, {22'h0, shadow[2][15:6]});
        chk_val({31'h0, ch2_highpass_off}, {31'h0, shadow[2][2]});
        chk_val({30'h0, ch2_input_select}, {30'h0, shadow[2][1:0]});
        chk_val({8'h00, ch2_offset_value}, {8'h00, shadow[3], shadow[4][15:8]});
        chk_val({8'h00, ch2_gain_value}, {8'h00, shadow[5], shadow[6][15:8]});
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        shadow = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
    initial begin
        int i;
        rst_n = 1'b0;
        {address, read, write, writedata, byteenable} = '0;
        do_reset();
        check_outs();
        check_all();
        for (i = 0; i < 7; i++) put(i, 16'hffff, 4'hf);
        check_all();
        check_outs();
        for (i = 0; i < 4; i++) begin
            rng = xs(rng);
            put(2, {rng[15:2], 2'(i)}, 4'h3);
            check_outs();
            check_reg(2);
        end
        for (int k = 0; k < 40; k++) begin
            rng = xs(rng);
            i = int'(rng[10:8]) % 7;
            put(i, rng[31:16], rng[3:0]);
            check_reg(i);
            check_outs();
        end
        for (i = 0; i < 4; i++) begin
            xfer(1'b1, bad[i], 16'hffff, 4'hf);
            chk_resp(rs, 2'b11);
            xfer(1'b0, bad[i], 16'h0000, 4'hf);
            chk_val(rd, 32'h0000_0000);
            chk_resp(rs, 2'b11);
        end
        check_all();
        do_reset();
        check_all();
        check_outs();
        results();
    end
endmodule // accr_regs_test
`default_nettype wire
